// File: lan_reset_pkg.sv
// What this block does
// (R01) power-good low holds all registers reset except transmit bases, gap and filter address
// (R02) power-good low holds PHY reset asserted
// (R03) host reset floats all PCI outputs
// (R04) host reset restores groups, keeps filters
// (R05) host reset keeps transmit bases and gap
// (R06) PHY reset stretched 400 ns after release
// (R07) host reset release triggers EEPROM reload
// (R08) host reset enters Dr power state
// (R09) global bit 26 resets what host reset does, except PCI, PHY, power state and PME
// (R10) global reset spares config, PHY, pin directions
// (R11) link bit 3 holds link, stops autoneg
// (R12) link reset transmits /C/ ordered sets
// (R13) link reset clears received config word only
// (R14) EEPROM reload bit rereads EEPROM fields only
// (R15) PHY bit drives PHY reset only
// (R16) transmit reset forces data lines zero
// (R17) filters and bases survive; valid bit cleared
// (R18) wakeup status cleared only by power-good
// (R19) PME bits reset by power-good or no-aux host reset
// (R20) packet buffer never preset
// (R21) statistics init within 1 us of D0active
// (R22) global bit self-clears after a fixed 16-cycle hold
`default_nettype none
package lan_reset_pkg;
  localparam int unsigned CLK_MHZ          = 125;
  localparam int unsigned PHY_HOLD_NS      = 400;
  localparam int unsigned PHY_HOLD_CYC     = (PHY_HOLD_NS * CLK_MHZ) / 1000;
  localparam int unsigned STAT_INIT_US     = 1;
  localparam int unsigned STAT_INIT_CYC    = STAT_INIT_US * CLK_MHZ;
  localparam int unsigned GLOBAL_HOLD_CYC  = 16;
  localparam int unsigned EE_LOAD_CYC      = 32;
  localparam int unsigned CNT_W            = 8;
  // register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_EXT    = 8'h18;
  localparam logic [7:0] OFS_WAKE   = 8'h1C;
  localparam logic [7:0] OFS_RADDR  = 8'h20;
  localparam logic [7:0] OFS_RECEIVED_CONFIG_WORD   = 8'h24;
  localparam logic [7:0] OFS_TDBASE = 8'h28;
  localparam logic [7:0] OFS_GAP    = 8'h2C;
  localparam logic [7:0] OFS_GEN    = 8'h30;
  localparam logic [7:0] OFS_WSTAT  = 8'h34;
  localparam int unsigned CTRL_LINK_BIT   = 3;
  localparam int unsigned CTRL_PHY_BIT    = 31;
  localparam int unsigned CTRL_GLOBAL_BIT = 26;
  localparam int unsigned EXT_EE_BIT      = 13;
  localparam int unsigned RADDR_VALID_BIT = 31;
  localparam int unsigned WAKE_PME_EN_BIT = 1;
  localparam int unsigned WAKE_PME_ST_BIT = 2;
  localparam logic [31:0] GEN_RESET       = 32'h0000_0000;
  localparam logic [31:0] GAP_DEFAULT     = 32'h0060_200A;
  localparam logic [31:0] UNMAPPED_DATA   = 32'h0000_0000;
  localparam logic [9:0]  CONFIG_SET_C    = 10'h2B5;
  typedef enum logic [1:0] {PWR_D0U, PWR_D0A, PWR_DR} pwr_state_type;
  typedef struct packed {
    logic        phy_reset;
    logic        tx_zero;
    logic        link_hold;
    logic        autoneg_en;
    logic        ee_load;
    logic        stat_init;
    logic        pci_float;
  } reset_out_type;
endpackage : lan_reset_pkg
`default_nettype wire

// File: lan_reset_sequencer.sv
`default_nettype none
module lan_reset_sequencer (
  input  wire logic                  mclk,
  input  wire logic                  reset_n,
  input  wire logic                  power_good_in,
  input  wire logic                  host_reset_n_in,
  input  wire logic                  aux_power_in,
  input  wire logic                  mem_access_en_in,
  input  wire logic                  ee_done_in,
  input  wire logic [7:0]            address,
  input  wire logic                  read,
  input  wire logic                  write,
  input  wire logic [31:0]           writedata,
  output logic      [31:0]           readdata,
  output logic                       waitrequest,
  output lan_reset_pkg::reset_out_type ctl,
  output logic      [9:0]            tx_data,
  output lan_reset_pkg::pwr_state_type pwr_state,
  output logic                       pin_dir_keep
);
  localparam int unsigned CNT_W = lan_reset_pkg::CNT_W;
  logic [1:0]  pg_sync_r;
  logic [1:0]  hr_sync_r;
  logic [1:0]  aux_sync_r;
  logic [1:0]  mae_sync_r;
  logic [1:0]  eed_sync_r;
  logic        pg;
  logic        hr_act;
  logic        hr_prev_r;
  logic        hr_release;
  logic        ack_r;
  logic        ctrl_phy_r;
  logic        ctrl_link_r;
  logic        global_r;
  logic [CNT_W-1:0] global_cnt_r;
  logic [CNT_W-1:0] phy_cnt_r;
  logic [CNT_W-1:0] ee_cnt_r;
  logic        ee_busy_r;
  logic [CNT_W-1:0] stat_cnt_r;
  logic        stat_busy_r;
  logic        stat_done_r;
  logic        mae_prev_r;
  logic [31:0] gen_r;
  logic [31:0] raddr_r;
  logic [31:0] received_config_word_r;
  logic [31:0] tdbase_r;
  logic [31:0] gap_r;
  logic [31:0] wstat_r;
  logic        pme_en_r;
  logic        pme_st_r;
  logic        soft_rst;

  // pins cross in from outside the core clock
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pg_sync_r  <= 2'h0;
      hr_sync_r  <= 2'h0;
      aux_sync_r <= 2'h0;
      mae_sync_r <= 2'h0;
      eed_sync_r <= 2'h0;
    end
    else
    begin
      pg_sync_r  <= {pg_sync_r[0], power_good_in};
      hr_sync_r  <= {hr_sync_r[0], host_reset_n_in};
      aux_sync_r <= {aux_sync_r[0], aux_power_in};
      mae_sync_r <= {mae_sync_r[0], mem_access_en_in};
      eed_sync_r <= {eed_sync_r[0], ee_done_in};
    end
  end

  assign pg         = pg_sync_r[1];
  assign hr_act     = ~hr_sync_r[1] | ~pg;
  assign hr_release = hr_prev_r & ~hr_act;
  // (R09) global bit acts like host reset
  assign soft_rst   = hr_act | global_r;

  // one wait state: every access answers on its second edge
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ack_r     <= 1'b0;
      hr_prev_r <= 1'b1;
    end
    else
    begin
      ack_r     <= (read | write) & ~ack_r;
      hr_prev_r <= hr_act;
    end
  end
  assign waitrequest = (read | write) & ~ack_r;

  // (R22) global bit self-clears after hold
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      global_r     <= 1'b0;
      global_cnt_r <= '0;
    end
    else if (hr_act)
    begin
      global_r     <= 1'b0;
      global_cnt_r <= '0;
    end
    else if (write && ack_r && address == lan_reset_pkg::OFS_CTRL &&
             writedata[lan_reset_pkg::CTRL_GLOBAL_BIT])
    begin
      global_r     <= 1'b1;
      global_cnt_r <= CNT_W'(lan_reset_pkg::GLOBAL_HOLD_CYC);
    end
    else if (global_r)
    begin
      global_cnt_r <= global_cnt_r - 1'b1;
      if (global_cnt_r == CNT_W'(1))
        global_r <= 1'b0;
    end
  end

  // (R15) PHY bit touches nothing but PHY reset
  // (R11) link bit cleared by any full reset
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ctrl_phy_r  <= 1'b0;
      ctrl_link_r <= 1'b0;
    end
    else if (soft_rst)
    begin
      ctrl_phy_r  <= 1'b0;
      ctrl_link_r <= 1'b0;
    end
    else if (write && ack_r && address == lan_reset_pkg::OFS_CTRL)
    begin
      ctrl_phy_r  <= writedata[lan_reset_pkg::CTRL_PHY_BIT];
      ctrl_link_r <= writedata[lan_reset_pkg::CTRL_LINK_BIT];
    end
  end

  // (R02) (R06) PHY held through reset plus 400 ns
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      phy_cnt_r <= CNT_W'(lan_reset_pkg::PHY_HOLD_CYC);
    else if (hr_act)
      phy_cnt_r <= CNT_W'(lan_reset_pkg::PHY_HOLD_CYC);
    else if (phy_cnt_r != '0)
      phy_cnt_r <= phy_cnt_r - 1'b1;
  end

  // (R07) (R14) EEPROM reload on release or bit
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ee_busy_r <= 1'b0;
      ee_cnt_r  <= '0;
    end
    else if (hr_act)
    begin
      ee_busy_r <= 1'b0;
      ee_cnt_r  <= '0;
    end
    else if (hr_release || global_r ||
             (write && ack_r && address == lan_reset_pkg::OFS_EXT &&
              writedata[lan_reset_pkg::EXT_EE_BIT]))
    begin
      ee_busy_r <= 1'b1;
      ee_cnt_r  <= CNT_W'(lan_reset_pkg::EE_LOAD_CYC);
    end
    else if (ee_busy_r)
    begin
      if (ee_cnt_r != '0)
        ee_cnt_r <= ee_cnt_r - 1'b1;
      // loader done pin ends early; counter bounds a missing loader
      if (eed_sync_r[1] || ee_cnt_r == CNT_W'(1))
        ee_busy_r <= 1'b0;
    end
  end

  // (R21) statistics init within 1 us of D0active
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mae_prev_r  <= 1'b0;
      stat_busy_r <= 1'b0;
      stat_done_r <= 1'b0;
      stat_cnt_r  <= '0;
    end
    else if (soft_rst)
    begin
      mae_prev_r  <= 1'b0;
      stat_busy_r <= 1'b0;
      stat_done_r <= 1'b0;
      stat_cnt_r  <= '0;
    end
    else
    begin
      mae_prev_r <= mae_sync_r[1];
      if (mae_sync_r[1] && !mae_prev_r)
      begin
        stat_busy_r <= 1'b1;
        stat_done_r <= 1'b0;
        stat_cnt_r  <= CNT_W'(lan_reset_pkg::STAT_INIT_CYC - 1);
      end
      else if (stat_busy_r)
      begin
        stat_cnt_r <= stat_cnt_r - 1'b1;
        if (stat_cnt_r == '0)
        begin
          stat_busy_r <= 1'b0;
          stat_done_r <= 1'b1;
        end
      end
    end
  end

  // (R08) host reset puts function in Dr
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      pwr_state <= lan_reset_pkg::PWR_DR;
    else if (hr_act)
      pwr_state <= lan_reset_pkg::PWR_DR;
    else if (mae_sync_r[1])
      pwr_state <= lan_reset_pkg::PWR_D0A;
    else
      pwr_state <= lan_reset_pkg::PWR_D0U;
  end

  // (R04) (R09) general group back to power-on
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      gen_r <= lan_reset_pkg::GEN_RESET;
    else if (soft_rst)
      gen_r <= lan_reset_pkg::GEN_RESET;
    else if (write && ack_r && address == lan_reset_pkg::OFS_GEN)
      gen_r <= writedata;
  end

  // (R17) filter kept, only valid bit cleared
  // power-good low clears valid too, via hr_act
  always_ff @(posedge mclk)
  begin
    if (soft_rst)
      raddr_r[lan_reset_pkg::RADDR_VALID_BIT] <= 1'b0;
    else if (write && ack_r && address == lan_reset_pkg::OFS_RADDR)
      raddr_r <= writedata;
  end

  // (R05) transmit bases and gap survive host reset
  // (R20) no preset: storage without reset term
  always_ff @(posedge mclk)
  begin
    if (write && ack_r && !soft_rst &&
        address == lan_reset_pkg::OFS_TDBASE)
      tdbase_r <= writedata;
  end

  always_ff @(posedge mclk)
  begin
    if (write && ack_r && !soft_rst && address == lan_reset_pkg::OFS_GAP)
      gap_r <= writedata;
  end

  // (R13) link reset clears received config word only
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      received_config_word_r <= '0;
    else if (soft_rst || ctrl_link_r)
      received_config_word_r <= '0;
    else if (write && ack_r && address == lan_reset_pkg::OFS_RECEIVED_CONFIG_WORD)
      received_config_word_r <= writedata;
  end

  // (R18) wakeup status cleared by power-good only
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      wstat_r <= '0;
    else if (!pg)
      wstat_r <= '0;
    else if (write && ack_r && address == lan_reset_pkg::OFS_WSTAT)
      wstat_r <= writedata;
  end

  // (R19) PME kept over host reset with aux power
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pme_en_r <= 1'b0;
      pme_st_r <= 1'b0;
    end
    else if (!pg || (hr_release && !aux_sync_r[1]))
    begin
      pme_en_r <= 1'b0;
      pme_st_r <= 1'b0;
    end
    else if (write && ack_r && address == lan_reset_pkg::OFS_WAKE)
    begin
      pme_en_r <= writedata[lan_reset_pkg::WAKE_PME_EN_BIT];
      // a one written to the status bit clears it; nothing here sets it
      pme_st_r <= pme_st_r & ~writedata[lan_reset_pkg::WAKE_PME_ST_BIT];
    end
  end

  // (R12) (R16) transmit line forcing
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      tx_data <= '0;
    else if (soft_rst)
      tx_data <= '0;
    else if (ctrl_link_r)
      tx_data <= lan_reset_pkg::CONFIG_SET_C;
    else
      tx_data <= '0;
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      readdata <= '0;
    else if (read && !ack_r)
      unique case (address)
        lan_reset_pkg::OFS_CTRL:
          readdata <= {ctrl_phy_r, 4'h0, global_r, 22'h0, ctrl_link_r, 3'h0};
        lan_reset_pkg::OFS_STATUS:
          readdata <= {26'h0, stat_done_r, stat_busy_r, ee_busy_r,
                       pwr_state, pg};
        lan_reset_pkg::OFS_EXT:
          readdata <= {18'h0, ee_busy_r, 13'h0};
        lan_reset_pkg::OFS_WAKE:
          readdata <= {29'h0, pme_st_r, pme_en_r, 1'b0};
        lan_reset_pkg::OFS_RADDR:  readdata <= raddr_r;
        lan_reset_pkg::OFS_RECEIVED_CONFIG_WORD:   readdata <= received_config_word_r;
        lan_reset_pkg::OFS_TDBASE: readdata <= tdbase_r;
        lan_reset_pkg::OFS_GAP:    readdata <= gap_r;
        lan_reset_pkg::OFS_GEN:    readdata <= gen_r;
        lan_reset_pkg::OFS_WSTAT:  readdata <= wstat_r;
        default:                   readdata <= lan_reset_pkg::UNMAPPED_DATA;
      endcase
  end

  // (R01) (R03) (R11) reset outputs
  always_comb
  begin
    ctl            = '0;
    // (R02) (R10) global reset leaves the PHY alone
    ctl.phy_reset  = ~pg | hr_act | (phy_cnt_r != '0) | ctrl_phy_r;
    ctl.tx_zero    = soft_rst;
    ctl.link_hold  = ctrl_link_r | soft_rst;
    ctl.autoneg_en = ~ctrl_link_r & ~soft_rst;
    ctl.ee_load    = ee_busy_r;
    ctl.stat_init  = stat_busy_r;
    ctl.pci_float  = hr_act;
  end

  // (R10) pin directions live outside this reset
  assign pin_dir_keep = global_r;
endmodule : lan_reset_sequencer
`default_nettype wire

// File: lan_reset_sequencer_properties.sv
`default_nettype none
module lan_reset_sequencer_checker (
  input wire logic                         mclk,
  input wire logic                         reset_n,
  input wire logic                         power_good_in,
  input wire logic                         host_reset_n_in,
  input wire logic                         mem_access_en_in,
  input wire logic [7:0]                   address,
  input wire logic                         write,
  input wire logic [31:0]                  writedata,
  input wire logic                         waitrequest,
  input wire lan_reset_pkg::reset_out_type ctl,
  input wire logic [9:0]                   tx_data,
  input wire lan_reset_pkg::pwr_state_type pwr_state,
  input wire logic                         pin_dir_keep
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  // pins pass a two-flop synchroniser, hence the three-cycle lead-ins;
  // registered power state needs one cycle more
  a_pg_phy_hold: assert property (
    !power_good_in [*3] |-> ctl.phy_reset)
    else $error("phy reset low while power is bad");
  a_host_float: assert property (
    !host_reset_n_in [*3] |-> ctl.pci_float)
    else $error("bus outputs driven in host reset");
  a_host_dr_state: assert property (
    !host_reset_n_in [*4] |-> pwr_state == lan_reset_pkg::PWR_DR)
    else $error("power state not Dr in host reset");
  a_phy_stretch: assert property (
    $rose(host_reset_n_in) && power_good_in
      |-> ##49 ctl.phy_reset ##[1:8] !ctl.phy_reset)
    else $error("phy reset stretch wrong");
  a_ee_on_release: assert property (
    $rose(host_reset_n_in) |-> ##[1:60] ctl.ee_load)
    else $error("no eeprom reload after host reset");
  a_tx_forced_zero: assert property (
    ctl.tx_zero [*2] |-> tx_data == 10'h000)
    else $error("tx data not zero in reset");
  a_link_config: assert property (
    (ctl.link_hold && !ctl.tx_zero) [*2]
      |-> tx_data == lan_reset_pkg::CONFIG_SET_C)
    else $error("no config set in link reset");
  a_link_no_aneg: assert property (
    ctl.link_hold |-> !ctl.autoneg_en)
    else $error("autoneg on in link reset");
  a_global_start: assert property (
    write && !waitrequest && address == lan_reset_pkg::OFS_CTRL
      && writedata[26] |-> ##[1:4] ctl.tx_zero && pin_dir_keep)
    else $error("global reset did not start");
  a_global_clears: assert property (
    $rose(pin_dir_keep) |-> pin_dir_keep [*8] ##[1:20] !pin_dir_keep)
    else $error("global reset did not self clear");
  a_stat_window: assert property (
    $rose(mem_access_en_in)
      |-> ##[1:6] ctl.stat_init ##[1:126] !ctl.stat_init)
    else $error("statistics init too slow");
endmodule : lan_reset_sequencer_checker
bind lan_reset_sequencer lan_reset_sequencer_checker
  lan_reset_sequencer_checker_i (
  .mclk(mclk),
  .reset_n(reset_n),
  .power_good_in(power_good_in),
  .host_reset_n_in(host_reset_n_in),
  .mem_access_en_in(mem_access_en_in),
  .address(address),
  .write(write),
  .writedata(writedata),
  .waitrequest(waitrequest),
  .ctl(ctl),
  .tx_data(tx_data),
  .pwr_state(pwr_state),
  .pin_dir_keep(pin_dir_keep)
);
`default_nettype wire

// File: host_model.sv
`default_nettype none
module host_model (
  input  wire logic        mclk,
  input  wire logic        waitrequest,
  input  wire logic [31:0] readdata,
  input  wire logic        ee_load,
  output logic             power_good_in,
  output logic             host_reset_n_in,
  output logic             aux_power_in,
  output logic             mem_access_en_in,
  output logic             ee_done_in,
  output logic [7:0]       address,
  output logic             read,
  output logic             write,
  output logic [31:0]      writedata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] ee_dly_r = 4'h0;
  // eeprom answers a few cycles late, never at once
  always @(posedge mclk) ee_dly_r <= {ee_dly_r[2:0], ee_load};
  assign ee_done_in = ee_dly_r[3];
  initial
  begin
    {power_good_in, host_reset_n_in, aux_power_in} = 3'h6;
    {mem_access_en_in, read, write} = 3'h0;
    address = 8'hFF;
    writedata = 32'h0000_0000;
  end
  task automatic pins(input logic pg, hr, aux, mem);
    power_good_in <= pg;
    host_reset_n_in <= hr;
    aux_power_in <= aux;
    mem_access_en_in <= mem;
  endtask : pins
  // released lines show inverted data so stale values never match
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    address <= a;
    writedata <= v;
    write <= 1'b1;
    @(posedge mclk);
    while (waitrequest !== 1'b0)
      @(posedge mclk);
    write <= 1'b0;
    address <= ~a;
    writedata <= ~v;
    @(posedge mclk);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    address <= a;
    read <= 1'b1;
    @(posedge mclk);
    while (waitrequest !== 1'b0)
      @(posedge mclk);
    q = readdata;
    read <= 1'b0;
    address <= ~a;
    @(posedge mclk);
  endtask : rd
endmodule : host_model
`default_nettype wire

// File: lan_reset_sequencer_tb.sv
`default_nettype none
module lan_reset_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                         mclk;
  logic                         reset_n;
  logic                         pg, hr, aux, mem, eed, rd_s, wr_s, wait_s;
  logic [7:0]                   addr;
  logic [31:0]                  wdat, rdat, d;
  lan_reset_pkg::reset_out_type ctl;
  logic [9:0]                   tx_data;
  lan_reset_pkg::pwr_state_type pwr_state;
  logic                         pin_dir_keep;
  int                           err_count = 0;
  int                           samples_checked = 0;
  int                           cyc = 0;
  lan_reset_sequencer lan_reset_sequencer_i (.mclk(mclk), .reset_n(reset_n),
    .power_good_in(pg), .host_reset_n_in(hr), .aux_power_in(aux),
    .mem_access_en_in(mem), .ee_done_in(eed), .address(addr), .read(rd_s),
    .write(wr_s), .writedata(wdat), .readdata(rdat), .waitrequest(wait_s),
    .ctl(ctl), .tx_data(tx_data), .pwr_state(pwr_state),
    .pin_dir_keep(pin_dir_keep));
  host_model host_model_i (.mclk(mclk), .waitrequest(wait_s), .readdata(rdat),
    .ee_load(ctl.ee_load), .power_good_in(pg), .host_reset_n_in(hr),
    .aux_power_in(aux), .mem_access_en_in(mem), .ee_done_in(eed),
    .address(addr), .read(rd_s), .write(wr_s), .writedata(wdat));
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  task automatic summarize();
    $display("checked %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : summarize
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      err_count++;
      summarize();
    end
  end
  task automatic chkb(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chkb
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    host_model_i.rd(a, d);
    samples_checked++;
    if (d !== exp)
    begin
      err_count++;
      $display("unexpected at %0t got %h exp %h", $time, d, exp);
    end
  endtask : rdchk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    host_model_i.wr(a, v);
  endtask : wr
  // phy stretch is fixed; eeprom load is polled with a bound
  task automatic settle();
    int n = 0;
    repeat (60) @(posedge mclk);
    host_model_i.rd(lan_reset_pkg::OFS_STATUS, d);
    while (d[3] !== 1'b0 && n < 100)
    begin
      host_model_i.rd(lan_reset_pkg::OFS_STATUS, d);
      n++;
    end
    chkb(d[3], 1'b0);
  endtask : settle
  task automatic t_stat();
    int n = 0;
    host_model_i.pins(1'b1, 1'b1, 1'b0, 1'b1);
    while (ctl.stat_init !== 1'b1 && n < 8)
      @(posedge mclk) n++;
    chkb(ctl.stat_init, 1'b1);
    n = 0;
    while (ctl.stat_init !== 1'b0 && n < 300)
      @(posedge mclk) n++;
    chkb(n <= lan_reset_pkg::STAT_INIT_CYC + 2, 1'b1);
    $display("t_stat done");
  endtask : t_stat
  task automatic t_host(input logic ax);
    wr(lan_reset_pkg::OFS_GEN, 32'hA5A5_0F0F);
    wr(lan_reset_pkg::OFS_RADDR, 32'h8000_1234);
    wr(lan_reset_pkg::OFS_TDBASE, 32'h1234_5670);
    wr(lan_reset_pkg::OFS_GAP, 32'h0000_0ABC);
    wr(lan_reset_pkg::OFS_WAKE, 32'h0000_0002);
    wr(lan_reset_pkg::OFS_WSTAT, 32'h0000_0005);
    host_model_i.pins(1'b1, 1'b0, ax, 1'b1);
    repeat (4) @(posedge mclk);
    chkb(ctl.pci_float, 1'b1);
    chkb(pwr_state == lan_reset_pkg::PWR_DR, 1'b1);
    host_model_i.pins(1'b1, 1'b1, ax, 1'b1);
    settle();
    rdchk(lan_reset_pkg::OFS_GEN, lan_reset_pkg::GEN_RESET);
    rdchk(lan_reset_pkg::OFS_RADDR, 32'h0000_1234);
    rdchk(lan_reset_pkg::OFS_TDBASE, 32'h1234_5670);
    rdchk(lan_reset_pkg::OFS_GAP, 32'h0000_0ABC);
    rdchk(lan_reset_pkg::OFS_WSTAT, 32'h0000_0005);
    host_model_i.rd(lan_reset_pkg::OFS_WAKE, d);
    chkb(d[1], ax);
    $display("t_host done");
  endtask : t_host
  task automatic t_sw();
    wr(lan_reset_pkg::OFS_GEN, 32'h0000_00C3);
    wr(lan_reset_pkg::OFS_CTRL, 32'h0000_0008);
    repeat (3) @(posedge mclk);
    chkb(ctl.link_hold && !ctl.autoneg_en, 1'b1);
    chkb(tx_data === lan_reset_pkg::CONFIG_SET_C, 1'b1);
    rdchk(lan_reset_pkg::OFS_RECEIVED_CONFIG_WORD, 32'h0000_0000);
    rdchk(lan_reset_pkg::OFS_GEN, 32'h0000_00C3);
    wr(lan_reset_pkg::OFS_CTRL, 32'h8000_0000);
    repeat (3) @(posedge mclk);
    chkb(ctl.autoneg_en, 1'b1);
    chkb(ctl.phy_reset, 1'b1);
    rdchk(lan_reset_pkg::OFS_GEN, 32'h0000_00C3);
    wr(lan_reset_pkg::OFS_CTRL, 32'h0000_0000);
    repeat (3) @(posedge mclk);
    chkb(ctl.phy_reset, 1'b0);
    wr(lan_reset_pkg::OFS_EXT, 32'h0000_2000);
    repeat (3) @(posedge mclk);
    chkb(ctl.ee_load, 1'b1);
    settle();
    rdchk(lan_reset_pkg::OFS_GEN, 32'h0000_00C3);
    $display("t_sw done");
  endtask : t_sw
  task automatic t_global();
    int n = 0;
    wr(lan_reset_pkg::OFS_GEN, 32'h0000_5A5A);
    wr(lan_reset_pkg::OFS_TDBASE, 32'h0BAD_0000);
    wr(lan_reset_pkg::OFS_CTRL, 32'h0400_0000);
    repeat (3) @(posedge mclk);
    chkb(ctl.tx_zero && tx_data === 10'h000, 1'b1);
    chkb(pin_dir_keep && !ctl.phy_reset, 1'b1);
    host_model_i.rd(lan_reset_pkg::OFS_CTRL, d);
    // polling is how software learns the sequence finished
    while (d[26] !== 1'b0 && n < 40)
    begin
      host_model_i.rd(lan_reset_pkg::OFS_CTRL, d);
      n++;
    end
    chkb(d[26], 1'b0);
    settle();
    rdchk(lan_reset_pkg::OFS_GEN, lan_reset_pkg::GEN_RESET);
    rdchk(lan_reset_pkg::OFS_TDBASE, 32'h0BAD_0000);
    rdchk(lan_reset_pkg::OFS_WSTAT, 32'h0000_0005);
    rdchk(lan_reset_pkg::OFS_RADDR, 32'h0000_1234);
    $display("t_global done");
  endtask : t_global
  task automatic t_pg();
    wr(lan_reset_pkg::OFS_GEN, 32'h0000_7777);
    wr(lan_reset_pkg::OFS_RADDR, 32'h8000_1234);
    wr(8'hF0, 32'h1111_1111);
    rdchk(8'hF0, lan_reset_pkg::UNMAPPED_DATA);
    host_model_i.pins(1'b0, 1'b1, 1'b0, 1'b1);
    repeat (4) @(posedge mclk);
    chkb(ctl.phy_reset, 1'b1);
    host_model_i.pins(1'b1, 1'b1, 1'b0, 1'b1);
    settle();
    rdchk(lan_reset_pkg::OFS_GEN, lan_reset_pkg::GEN_RESET);
    host_model_i.rd(lan_reset_pkg::OFS_RADDR, d);
    chkb(d[31], 1'b0);
    rdchk(lan_reset_pkg::OFS_WSTAT, 32'h0000_0000);
    $display("t_pg done");
  endtask : t_pg
  initial
  begin
    reset_n = 1'b0;
    repeat (12) @(posedge mclk);
    reset_n <= 1'b1;
    settle();
    t_stat();
    t_host(1'b1);
    t_host(1'b0);
    t_sw();
    t_global();
    t_pg();
    summarize();
  end
endmodule : lan_reset_sequencer_tb
`default_nettype wire
